// [status_outcome_consts.vh]
// Constants for the receive-status outcome reporter.
// Assumes inclusion by bare name from the design file.
`ifndef STATUS_OUTCOME_CONSTS_VH
`define STATUS_OUTCOME_CONSTS_VH

// Cause codes
`define CAUSE_RESET        8'h01
`define CAUSE_REG_PARITY   8'h22
`define CAUSE_BUS_PARITY   8'h24
`define CAUSE_HS_TIMEOUT   8'h2C
`define CAUSE_BAD_PHASE    8'h54
`define CAUSE_MSG_TAKEN    8'h55
`define CAUSE_MSG_DECLINED 8'h5D
`define CAUSE_DONE         8'h60
`define CAUSE_PREEMPTED    8'h64
`define CAUSE_ILLEGAL      8'h65
`define CAUSE_BUF_BUSY     8'h6C
`define CAUSE_BUS_FREE     8'h70

// Step codes
`define STEP_00            8'h00
`define STEP_01            8'h01
`define STEP_02            8'h02
`define STEP_09            8'h09
`define STEP_0A            8'h0A

// Bus phase encoding {msg, cd, io}
`define PHASE_STATUS       3'h3
`define PHASE_MSG_IN       3'h7

// Command codes of the interpreter
`define CMD_RECV_STATUS    4'h1
`define CMD_XFER           4'h2
`define CMD_RESELECT       4'h3
`define CMD_INIT_ONLY      4'h4

// Handshake timeout in cycles, default
`define HS_TIMEOUT_CYC     16'h0400

`endif

// [status_outcome_reporter.v]
// Receive-status command interpreter and outcome reporter.
// Assumes bus pins arrive unsynchronised; host side is on clk_sys.
// Notes on behaviour
// - reset before transfer gives 01/00
// - reset during status byte gives 01/01
// - manual ack, parity error gives 24/01
// - auto ack, parity error releases ACK, 24/09
// - handshake timeout gives 2C/01
// - first REQ not status phase: 54/01
// - auto receive, message taken: 55/01
// - auto receive, buffer busy: 5D/01
// - manual ack success: 60/02, ACK held
// - auto ack success: release ACK, 60/0A
// - buffer occupied refuses status: 6C/01
// - bus free before transfer: 70/00
// - target role, command while waiting for REQ: result then 64/00
// - target role, pending interrupt skips new command: 64
// - target role illegal command: 65/00
// - nexus misordering answered with 65/00
// - host register parity error: 22/00
`timescale 1ns/1ps
`default_nettype none
`include "status_outcome_consts.vh"

module status_outcome_reporter (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       nrst,
  // Host command port
  input  wire       cmd_valid,
  input  wire [3:0] cmd_code,
  input  wire       target_role,
  input  wire       nexus_up,
  input  wire       auto_ack_mode,
  input  wire       auto_recv_mode,
  input  wire       reg_parity_err,
  input  wire       release_ack,
  input  wire       host_read,
  input  wire       buf_occupied,
  // Bus pins
  input  wire       scsi_rst_pin,
  input  wire       scsi_req_pin,
  input  wire       scsi_bsy_pin,
  input  wire       scsi_sel_pin,
  input  wire [2:0] scsi_phase_pin,
  input  wire [7:0] scsi_data_pin,
  input  wire       scsi_parity_pin,
  output reg        scsi_ack,
  // Outcome
  output reg        irq,
  output reg  [7:0] cause_code,
  output reg  [7:0] step_code,
  output reg  [7:0] status_byte,
  output reg        msg_valid,
  output reg  [7:0] msg_byte
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_WAIT = 5'h02;
  localparam [4:0] ST_ACK  = 5'h04;
  localparam [4:0] ST_HOLD = 5'h08;
  localparam [4:0] ST_DROP = 5'h10;

  // Three-stage synchronisers; change counts when stages 2 and 3 agree
  reg  [15:0] s1_q;
  reg  [15:0] s2_q;
  reg  [15:0] s3_q;
  reg  [15:0] in_q;
  wire [15:0] pins = {scsi_rst_pin, scsi_req_pin, scsi_bsy_pin,
                      scsi_sel_pin, scsi_phase_pin, scsi_data_pin,
                      scsi_parity_pin};
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
      s3_q <= 16'h0000;
      in_q <= 16'h0000;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Agreeing stages are taken in both directions, else hold
      in_q <= (in_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
    end
  end

  wire       rst_s    = in_q[15];
  wire       req_s    = in_q[14];
  wire       bus_free = !in_q[13] && !in_q[12];
  wire [2:0] phase_s  = in_q[11:9];
  wire [7:0] data_s   = in_q[8:1];
  wire       par_ok   = ^{data_s, in_q[0]}; // Odd parity on the bus

  // Command classification
  wire is_recv = (cmd_code == `CMD_RECV_STATUS);
  wire illegal = (target_role && (cmd_code == `CMD_INIT_ONLY)) ||
                 (cmd_code == 4'h0) || (cmd_code > `CMD_INIT_ONLY) ||
                 (cmd_code == `CMD_XFER && !nexus_up) ||
                 (cmd_code == `CMD_RESELECT && nexus_up);

  reg  [4:0]  st_q;
  reg  [15:0] tmo_q;
  reg         par_err_q;
  reg         dbl_q;     // Second command pending report
  reg  [7:0]  pc_q;      // Pending cause queued behind current one
  reg  [7:0]  ps_q;
  reg         pend_q;

  // Post a report; if one is held, queue it in the one pending slot
  task post;
    input [7:0] c;
    input [7:0] s;
    begin
      if (irq && !host_read) begin
        pc_q   <= c;
        ps_q   <= s;
        pend_q <= 1'b1;
      end else begin
        cause_code <= c;
        step_code  <= s;
        irq        <= 1'b1;
      end
    end
  endtask

  // Main sequencer
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      tmo_q <= 16'h0000;
      par_err_q <= 1'b0;
      dbl_q <= 1'b0;
      pc_q <= 8'h00;
      ps_q <= 8'h00;
      pend_q <= 1'b0;
      scsi_ack <= 1'b0;
      irq <= 1'b0;
      cause_code <= 8'h00;
      step_code <= 8'h00;
      status_byte <= 8'h00;
      msg_valid <= 1'b0;
      msg_byte <= 8'h00;
    end else begin
      msg_valid <= 1'b0;
      // Held until read, then queued report moves up
      if (irq && host_read) begin
        if (pend_q) begin
          cause_code <= pc_q;
          step_code <= ps_q;
          pend_q <= 1'b0;
        end else begin
          irq <= 1'b0;
        end
      end
      if (reg_parity_err) begin
        post(`CAUSE_REG_PARITY, `STEP_00);
      end
      case (st_q)
        ST_IDLE: begin
          if (cmd_valid) begin
            if (irq && target_role) begin
              post(`CAUSE_PREEMPTED, `STEP_00);
            end else if (illegal) begin
              post(`CAUSE_ILLEGAL, `STEP_00);
            end else if (is_recv) begin
              tmo_q <= 16'h0000;
              par_err_q <= 1'b0;
              st_q <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (cmd_valid && target_role) begin
            dbl_q <= 1'b1;
          end
          tmo_q <= tmo_q + 16'h0001;
          if (rst_s) begin
            post(`CAUSE_RESET, `STEP_00);
            st_q <= ST_IDLE;
          end else if (bus_free) begin
            post(`CAUSE_BUS_FREE, `STEP_00);
            st_q <= ST_IDLE;
          end else if (tmo_q == `HS_TIMEOUT_CYC) begin
            post(`CAUSE_HS_TIMEOUT, `STEP_01);
            st_q <= ST_IDLE;
          end else if (req_s) begin
            if (phase_s == `PHASE_STATUS && buf_occupied) begin
              post(`CAUSE_BUF_BUSY, `STEP_01);
              st_q <= ST_IDLE;
            end else if (phase_s == `PHASE_STATUS) begin
              status_byte <= data_s;
              par_err_q <= !par_ok;
              scsi_ack <= 1'b1;
              tmo_q <= 16'h0000;
              st_q <= ST_ACK;
            end else if (phase_s == `PHASE_MSG_IN && auto_recv_mode &&
                         buf_occupied) begin
              post(`CAUSE_MSG_DECLINED, `STEP_01);
              st_q <= ST_IDLE;
            end else if (phase_s == `PHASE_MSG_IN && auto_recv_mode) begin
              msg_byte <= data_s;
              msg_valid <= 1'b1;
              scsi_ack <= 1'b1;
              par_err_q <= 1'b1; // Marks message path for ACK drop
              st_q <= ST_DROP;
            end else begin
              post(`CAUSE_BAD_PHASE, `STEP_01);
              st_q <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          tmo_q <= tmo_q + 16'h0001;
          if (rst_s) begin
            scsi_ack <= 1'b0;
            post(`CAUSE_RESET, `STEP_01);
            st_q <= ST_IDLE;
          end else if (tmo_q == `HS_TIMEOUT_CYC) begin
            scsi_ack <= 1'b0;
            post(`CAUSE_HS_TIMEOUT, `STEP_01);
            st_q <= ST_IDLE;
          end else if (!req_s) begin
            if (auto_ack_mode) begin
              scsi_ack <= 1'b0;
              if (par_err_q) post(`CAUSE_BUS_PARITY, `STEP_09);
              else post(`CAUSE_DONE, `STEP_0A);
              st_q <= ST_IDLE;
            end else begin
              if (par_err_q) post(`CAUSE_BUS_PARITY, `STEP_01);
              else post(`CAUSE_DONE, `STEP_02);
              st_q <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          // Last ACK stays asserted until software lets it go or a bus reset is seen
          if (release_ack || rst_s) begin
            scsi_ack <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        ST_DROP: begin
          if (!req_s || rst_s) begin
            scsi_ack <= 1'b0;
            post(`CAUSE_MSG_TAKEN, `STEP_01);
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      // Double command: queued behind the first command's result
      if (dbl_q && st_q == ST_IDLE && !pend_q) begin
        dbl_q <= 1'b0;
        post(`CAUSE_PREEMPTED, `STEP_00);
      end
    end
  end

endmodule // status_outcome_reporter
`default_nettype wire

// [status_outcome_reporter_monitor.sv]
// Checker on the outcome reporter's host-side ports.
// Assumes one clk_sys domain reset by nrst, low active.
`timescale 1ns/1ps
`default_nettype none
module status_outcome_reporter_monitor (
  // Block inputs
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic       target_role,
  input wire logic       nexus_up,
  input wire logic       auto_ack_mode,
  input wire logic       reg_parity_err,
  input wire logic       release_ack,
  input wire logic       host_read,
  // Block outputs
  input wire logic       scsi_ack,
  input wire logic       irq,
  input wire logic [7:0] cause_code,
  input wire logic [7:0] step_code
);
  // One domain, so clock and reset are given once
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Reports tied to their causes; the nexus check compares the cause code only
  a_codes_held: assert property (irq && !host_read |=>
    irq && $stable({cause_code, step_code})) else $error("codes moved");
  a_reg_parity: assert property (reg_parity_err && !irq |->
    ##[1:4] irq && {cause_code, step_code} == 16'h2200) else $error("no 22");
  a_bad_code: assert property (target_role && cmd_valid && !irq &&
    (cmd_code == 4'h0 || cmd_code > 4'h3) |=> irq &&
    {cause_code, step_code} == 16'h6500) else $error("no 65 code");
  a_nexus_order: assert property (target_role && cmd_valid &&
    !irq && (cmd_code == 4'h2 && !nexus_up || cmd_code == 4'h3 && nexus_up)
    |=> irq && cause_code == 8'h65) else $error("no 65 order");
  a_preempt_next: assert property (target_role && irq && cmd_valid &&
    !host_read ##1 host_read |-> ##[1:2] irq &&
    {cause_code, step_code} == 16'h6400) else $error("no 64");
  a_done_step: assert property ($rose(irq) && cause_code == 8'h60 |->
    step_code == (auto_ack_mode ? 8'h0A : 8'h02) &&
    scsi_ack == !auto_ack_mode) else $error("bad done pair");
  a_parity_step: assert property ($rose(irq) && cause_code == 8'h24 |->
    step_code == (auto_ack_mode ? 8'h09 : 8'h01)) else $error("bad 24 step");
  a_ack_held: assert property (irq && cause_code == 8'h60 &&
    scsi_ack && !release_ack |=> scsi_ack) else $error("ack dropped");
endmodule // status_outcome_reporter_monitor
bind status_outcome_reporter status_outcome_reporter_monitor u_mon (.clk_sys,
  .nrst, .cmd_valid, .cmd_code, .target_role, .nexus_up, .auto_ack_mode,
  .reg_parity_err, .release_ack, .host_read, .scsi_ack, .irq, .cause_code,
  .step_code);
`default_nettype wire

// [scsi_target_model.sv]
// Behavioural bus target: sends one byte per go pulse.
// Assumes go is raised just after a clk_sys edge.
`timescale 1ns/1ps
`default_nettype none
module scsi_target_model (
  // Bench control and bus
  input  wire logic       clk_sys,
  input  wire logic       go,
  input  wire logic [2:0] ph_sel,
  input  wire logic       bad_par,
  input  wire logic       scsi_ack,
  output var  logic       scsi_req_pin,
  output var  logic [2:0] scsi_phase_pin,
  output var  logic [7:0] scsi_data_pin,
  output var  logic       scsi_parity_pin
);
  // Data flips once released, so a stale byte can never match
  initial begin
    {scsi_req_pin, scsi_phase_pin, scsi_data_pin, scsi_parity_pin} = '0;
    forever begin
      @(posedge clk_sys iff go === 1'b1);
      #1 scsi_phase_pin = ph_sel;
      scsi_data_pin = 8'h5A;
      scsi_parity_pin = ~^scsi_data_pin ^ bad_par; // Odd unless broken
      scsi_req_pin = 1'b1;
      for (int i = 0; i < 64 && scsi_ack !== 1'b1; i++) @(posedge clk_sys) #1;
      scsi_req_pin = 1'b0;
      for (int i = 0; i < 64 && scsi_ack !== 1'b0; i++) @(posedge clk_sys) #1;
      scsi_data_pin = ~scsi_data_pin;
    end
  end
endmodule // scsi_target_model
`default_nettype wire

// [test_status_outcome_reporter.sv]
// Bench for the receive-status outcome reporter.
// Assumes the target model on the bus pins.
`timescale 1ns/1ps
`default_nettype none
module test_status_outcome_reporter;
  logic clk_sys = 0, nrst = 0, cmd_valid = 0, target_role = 0, nexus_up = 0;
  logic auto_ack_mode = 0, auto_recv_mode = 0, reg_parity_err = 0, go = 0;
  logic release_ack = 0, host_read = 0, buf_occupied = 0, bad_par = 0;
  logic scsi_rst_pin = 0, scsi_bsy_pin = 1, scsi_sel_pin = 0;
  logic scsi_req_pin, scsi_parity_pin, scsi_ack, irq, msg_valid;
  logic [3:0] cmd_code = 0;
  logic [2:0] ph_sel = 0, scsi_phase_pin;
  logic [7:0] scsi_data_pin, cause_code, step_code, status_byte, msg_byte;
  int n_mismatch = 0, cmp_count = 0;
  // 125 MHz clock
  always #4 clk_sys = ~clk_sys;
  status_outcome_reporter i_status_outcome_reporter (.clk_sys, .nrst,
    .cmd_valid, .cmd_code, .target_role, .nexus_up, .auto_ack_mode,
    .auto_recv_mode, .reg_parity_err, .release_ack, .host_read,
    .buf_occupied, .scsi_rst_pin, .scsi_req_pin, .scsi_bsy_pin,
    .scsi_sel_pin, .scsi_phase_pin, .scsi_data_pin, .scsi_parity_pin,
    .scsi_ack, .irq, .cause_code, .step_code, .status_byte, .msg_valid,
    .msg_byte);
  scsi_target_model i_scsi_target_model (.clk_sys, .go, .ph_sel, .bad_par,
    .scsi_ack, .scsi_req_pin, .scsi_phase_pin, .scsi_data_pin,
    .scsi_parity_pin);
  // Helpers: drive just after the edge, compare bytes
  task automatic tick; @(posedge clk_sys); #1; endtask
  task automatic cmp(input string n, input logic [7:0] e, s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Bounded wait for a report, check it, then read it away
  task automatic expect_codes(input logic [7:0] c, s);
    for (int i = 0; i < 1500 && irq !== 1'b1; i++) tick;
    if (irq !== 1'b1) begin
      n_mismatch++;
      report_and_stop;
    end
    cmp("cause", c, cause_code);
    cmp("step", s, step_code);
    host_read = 1;
    tick;
    host_read = 0;
  endtask
  // Settle synchronisers, then pulse one command
  task automatic cmd(input logic [3:0] c);
    repeat (12) tick;
    cmd_code = c;
    cmd_valid = 1;
    tick;
    cmd_valid = 0;
  endtask
  // Receive status with the target answering in phase p
  task automatic rx(input logic aa, bp, input logic [2:0] p);
    release_ack = 1;
    tick;
    release_ack = 0;
    // Let an unanswered REQ from the last byte fall first
    for (int i = 0; i < 100 && scsi_req_pin === 1'b1; i++) tick;
    {auto_ack_mode, bad_par, ph_sel, go} = {aa, bp, p, 1'b1};
    cmd(4'h1);
    go = 0;
  endtask
  // Bus reset, bus free, silent target
  task automatic t_early;
    scsi_rst_pin = 1;
    cmd(4'h1);
    expect_codes(8'h01, 8'h00);
    {scsi_rst_pin, scsi_bsy_pin} = 2'b00;
    cmd(4'h1);
    expect_codes(8'h70, 8'h00);
    scsi_bsy_pin = 1;
    cmd(4'h1);
    expect_codes(8'h2C, 8'h01);
  endtask
  // Clean and broken bytes in both ack modes
  task automatic t_ack_modes;
    rx(0, 0, 3'h3);
    expect_codes(8'h60, 8'h02);
    cmp("ack", 8'h01, {7'h00, scsi_ack});
    rx(1, 0, 3'h3);
    expect_codes(8'h60, 8'h0A);
    cmp("status", 8'h5A, status_byte);
    rx(0, 1, 3'h3);
    expect_codes(8'h24, 8'h01);
    rx(1, 1, 3'h3);
    expect_codes(8'h24, 8'h09);
  endtask
  // Wrong phase, message receive, busy buffer
  task automatic t_phase;
    rx(1, 0, 3'h1);
    expect_codes(8'h54, 8'h01);
    auto_recv_mode = 1;
    rx(1, 0, 3'h7);
    expect_codes(8'h55, 8'h01);
    buf_occupied = 1;
    rx(1, 0, 3'h7);
    expect_codes(8'h5D, 8'h01);
    auto_recv_mode = 0;
    rx(1, 0, 3'h3);
    expect_codes(8'h6C, 8'h01);
    buf_occupied = 0;
  endtask
  // Refused and preempted commands as target
  task automatic t_target;
    logic [3:0] bad [4] = '{4'h0, 4'h4, 4'h5, 4'hF};
    target_role = 1;
    foreach (bad[i]) begin
      cmd(bad[i]);
      expect_codes(8'h65, 8'h00);
    end
    cmd(4'h2);
    expect_codes(8'h65, 8'h00);
    nexus_up = 1;
    cmd(4'h3);
    expect_codes(8'h65, 8'h00);
    reg_parity_err = 1;
    tick;
    reg_parity_err = 0;
    cmd(4'h2);
    expect_codes(8'h22, 8'h00);
    expect_codes(8'h64, 8'h00);
    // Second command while a silent target holds the first in wait
    cmd(4'h1);
    cmd(4'h1);
    expect_codes(8'h2C, 8'h01);
    expect_codes(8'h64, 8'h00);
  endtask
  // Five reset cycles, then every scenario but a bus reset during a status byte
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 nrst = 1;
    t_early;
    t_ack_modes;
    t_phase;
    t_target;
    report_and_stop;
  end
endmodule // test_status_outcome_reporter
`default_nettype wire
